// ===== rtl/tmc_pkg.sv
// Package of constants, register map and types for the 8-bit timer/counter.
package tmc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses on the AHB-Lite slave)
  // ---------------------------------------------------------------
  localparam logic [7:0] TMC_ADDR_COUNT   = 8'h00;  // timer_count_value
  localparam logic [7:0] TMC_ADDR_OPTION  = 8'h04;  // option_settings
  localparam logic [7:0] TMC_ADDR_INTCTL  = 8'h08;  // interrupt_control
  localparam logic [7:0] TMC_ADDR_STATUS  = 8'h0c;  // Sticky event status, read only.
  localparam logic [7:0] TMC_ADDR_CLEAR   = 8'h10;  // Event clear, write only.
  localparam logic [7:0] TMC_ADDR_ENABLE  = 8'h14;  // Event interrupt enable.

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TMC_OPT_PULLUP_DIS = 7;  // port_pullup_disable
  localparam int TMC_OPT_IRQ_EDGE   = 6;  // ext_irq_edge
  localparam int TMC_OPT_SRC_SEL    = 5;  // count_source_select
  localparam int TMC_OPT_EDGE_SEL   = 4;  // source_edge_select
  localparam int TMC_OPT_PSC_ASSIGN = 3;  // prescaler_assign
  localparam int TMC_OPT_RATE_HI    = 2;  // prescale_rate msb
  localparam int TMC_INT_OVF_IE     = 5;  // overflow_irq_enable
  localparam int TMC_INT_OVF_FLAG   = 2;  // overflow_flag
  localparam int TMC_EVT_OVERFLOW   = 0;  // Status bit: count wrapped.
  localparam int TMC_EVT_EXT_EDGE   = 1;  // Status bit: counted edge seen.
  localparam int TMC_EVT_W          = 2;

  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] TMC_RST_OPTION  = 8'hff;
  localparam logic [7:0] TMC_RST_INTCTL  = 8'h00;
  localparam logic [7:0] TMC_RST_COUNT   = 8'h00;
  localparam logic [7:0] TMC_COUNT_MAX   = 8'hff;
  localparam logic [1:0] TMC_INHIBIT_CYC = 2'h2;  // Instruction cycles without count.

  // AHB-Lite encodings.
  localparam logic [1:0] TMC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] TMC_HTRANS_SEQ    = 2'h3;

  // Internal phase clock, Gray coded along Q1..Q4.
  typedef enum logic [1:0] {
    TMC_Q1 = 2'b00,
    TMC_Q2 = 2'b01,
    TMC_Q3 = 2'b11,
    TMC_Q4 = 2'b10
  } tmc_phase_t;

endpackage : tmc_pkg

// ===== rtl/tmc_sync.sv
// Three-stage synchroniser with an agreement filter for one pin input.
`timescale 1ns/1ps
`default_nettype none
module tmc_sync (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic pin_in,
  output logic      level_out
);

  logic meta_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic level_ff;

  // ---------------------------------------------------------------
  // Chain
  // ---------------------------------------------------------------
  // Only the second stage reads the first; the filter looks at the later two.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff  <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end else begin
      meta_ff  <= pin_in;
      sync2_ff <= meta_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // A change counts once the second and third stages agree.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      level_ff <= 1'b0;
    end else if (sync2_ff == sync3_ff) begin
      level_ff <= sync3_ff;
    end
  end

  assign level_out = level_ff;

endmodule : tmc_sync
`default_nettype wire

// ===== rtl/tmc_timer.sv
// Top of the 8-bit timer/counter with shared prescaler and AHB-Lite registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Source 0 counts instruction cycles, maybe prescaled.
// - Count write pauses counting two instruction cycles.
// - Source 1 counts external input transitions.
// - Edge select: 1 falling, 0 rising.
// - Prescaler serves timer or watchdog, never both.
// - Rate code selects 1:2 up to 1:256.
// - Watchdog-owned prescaler gives timer 1:1.
// - Prescaler hidden; count write clears it when assigned to timer.
// - Watchdog clear also clears prescaler when owned.
// - Wrap FFh to 00h sets overflow flag.
// - Flag sticky; request only while enabled.
// - Timer frozen during Sleep.
// - External count sampled on Q2 and Q4.
// - Pull-up disable bit kills all pull-ups.
// - Interrupt edge bit: 1 rising, 0 falling.
module tmc_timer
  import tmc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        ext_count_input,
  input  wire logic        sleep,
  input  wire logic        watchdog_tick,
  input  wire logic        watchdog_clear_instr,
  output logic             overflow_irq_req,
  output logic             irq,
  output logic             port_pullup_disable,
  output logic             ext_irq_edge
);

  logic [7:0]          count_ff;
  logic [7:0]          option_ff;
  logic [7:0]          intctl_ff;
  logic [7:0]          psc_ff;
  logic [1:0]          inhibit_ff;
  tmc_phase_t          phase_ff;
  logic                ext_smp_ff;
  logic [TMC_EVT_W-1:0] status_ff;
  logic [TMC_EVT_W-1:0] enable_ff;
  logic                irq_ff;
  logic                req_ff;
  logic                hready_ff;
  logic [31:0]         hrdata_ff;
  logic                wr_pend_ff;
  logic [7:0]          wr_addr_ff;
  logic                ext_lvl;
  logic                addr_ok;
  logic                q4_tick;
  logic                ext_edge;
  logic                src_evt;
  logic                psc_to_timer;
  logic [7:0]          tap_mask;
  logic                cnt_inc;
  logic                wr_count;
  logic                wr_option;
  logic                wr_intctl;
  logic                wr_clear;
  logic                wr_enable;
  logic                ovf_evt;
  logic [31:0]         nxt_hrdata;

  // ---------------------------------------------------------------
  // External count input synchroniser
  // ---------------------------------------------------------------
  tmc_sync u_ext_sync (
    .clock     (clock),
    .arst_n    (arst_n),
    .pin_in    (ext_count_input),
    .level_out (ext_lvl)
  );

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  // Zero wait states: every transfer is answered in its first data cycle.
  assign addr_ok = hsel && hready &&
                   (htrans == TMC_HTRANS_NONSEQ || htrans == TMC_HTRANS_SEQ);

  // Read data is prepared in the address phase so it leaves a flop.
  always_comb begin
    nxt_hrdata = 32'h0000_0000;
    unique case (haddr[7:0])
      TMC_ADDR_COUNT:  nxt_hrdata[7:0] = count_ff;
      TMC_ADDR_OPTION: nxt_hrdata[7:0] = option_ff;
      TMC_ADDR_INTCTL: nxt_hrdata[7:0] = intctl_ff;
      TMC_ADDR_STATUS: nxt_hrdata[TMC_EVT_W-1:0] = status_ff;
      TMC_ADDR_ENABLE: nxt_hrdata[TMC_EVT_W-1:0] = enable_ff;
      default:         nxt_hrdata = 32'h0000_0000;
    endcase
  end

  // Address phase capture; reads decode haddr[7:0] only, unmapped offsets read zero; writes outside the map are ignored.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff  <= 32'h0000_0000;
      hready_ff  <= 1'b0;
    end else begin
      hready_ff  <= 1'b1;
      wr_pend_ff <= addr_ok && hwrite && haddr[31:8] == 24'h00_0000;
      if (addr_ok) begin
        wr_addr_ff <= haddr[7:0];
      end
      if (addr_ok && !hwrite) begin
        hrdata_ff <= nxt_hrdata;
      end
    end
  end

  assign wr_count  = wr_pend_ff && wr_addr_ff == TMC_ADDR_COUNT;
  assign wr_option = wr_pend_ff && wr_addr_ff == TMC_ADDR_OPTION;
  assign wr_intctl = wr_pend_ff && wr_addr_ff == TMC_ADDR_INTCTL;
  assign wr_clear  = wr_pend_ff && wr_addr_ff == TMC_ADDR_CLEAR;
  assign wr_enable = wr_pend_ff && wr_addr_ff == TMC_ADDR_ENABLE;

  // ---------------------------------------------------------------
  // Option register
  // ---------------------------------------------------------------
  // Rate, source and assignment written together take effect together.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      option_ff <= TMC_RST_OPTION;
    end else if (wr_option) begin
      option_ff <= hwdata[7:0];
    end
  end

  assign port_pullup_disable = option_ff[TMC_OPT_PULLUP_DIS];
  assign ext_irq_edge        = option_ff[TMC_OPT_IRQ_EDGE];

  // ---------------------------------------------------------------
  // Phase clock and instruction cycle
  // ---------------------------------------------------------------
  // Four system clocks make one instruction cycle; Sleep stops the phases.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_ff <= TMC_Q1;
    end else if (!sleep) begin
      unique case (phase_ff)
        TMC_Q1: phase_ff <= TMC_Q2;
        TMC_Q2: phase_ff <= TMC_Q3;
        TMC_Q3: phase_ff <= TMC_Q4;
        TMC_Q4: phase_ff <= TMC_Q1;
      endcase
    end
  end

  assign q4_tick = phase_ff == TMC_Q4 && !sleep;

  // External level is sampled only on Q2 and Q4, which sets the minimum
  // pulse width the pin must hold.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ext_smp_ff <= 1'b0;
    end else if (!sleep && (phase_ff == TMC_Q2 || phase_ff == TMC_Q4)) begin
      ext_smp_ff <= ext_lvl;
    end
  end

  // Edge on the sampled level, polarity picked by the edge select bit.
  assign ext_edge = !sleep && (phase_ff == TMC_Q2 || phase_ff == TMC_Q4) &&
                    (option_ff[TMC_OPT_EDGE_SEL] ?
                     (ext_smp_ff && !ext_lvl) : (!ext_smp_ff && ext_lvl));

  // Timer mode counts instruction cycles, counter mode counts edges.
  assign src_evt = option_ff[TMC_OPT_SRC_SEL] ? ext_edge : q4_tick;

  // ---------------------------------------------------------------
  // Shared prescaler
  // ---------------------------------------------------------------
  assign psc_to_timer = !option_ff[TMC_OPT_PSC_ASSIGN];
  // Bits 0..rate all set means the chosen tap falls on the next step.
  assign tap_mask = 8'(8'hff >> (3'd7 - option_ff[TMC_OPT_RATE_HI:0]));

  // The prescaler has no bus address; only writes and watchdog clears reach it.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      psc_ff <= 8'h00;
    end else if (psc_to_timer && wr_count) begin
      psc_ff <= 8'h00;
    end else if (!psc_to_timer && watchdog_clear_instr) begin
      psc_ff <= 8'h00;
    end else if (!sleep) begin
      if (psc_to_timer && src_evt && inhibit_ff == 2'h0) begin
        psc_ff <= psc_ff + 8'h01;
      end else if (!psc_to_timer && watchdog_tick) begin
        psc_ff <= psc_ff + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Count register
  // ---------------------------------------------------------------
  // With the prescaler on the watchdog the timer sees every source event.
  assign cnt_inc = !sleep && inhibit_ff == 2'h0 && !wr_count && src_evt &&
                   (!psc_to_timer || (psc_ff & tap_mask) == tap_mask);

  // Write pause, counted in instruction cycles after the write.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      inhibit_ff <= 2'h0;
    end else if (wr_count) begin
      inhibit_ff <= TMC_INHIBIT_CYC;
    end else if (q4_tick && inhibit_ff != 2'h0) begin
      inhibit_ff <= inhibit_ff - 2'h1;
    end
  end

  // A bus write beats a coincident increment.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_ff <= TMC_RST_COUNT;
    end else if (wr_count) begin
      count_ff <= hwdata[7:0];
    end else if (cnt_inc) begin
      count_ff <= count_ff + 8'h01;
    end
  end

  assign ovf_evt = cnt_inc && count_ff == TMC_COUNT_MAX;

  // ---------------------------------------------------------------
  // Interrupt control and event status
  // ---------------------------------------------------------------
  // The overflow flag is set regardless of its enable; set wins over clear.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      intctl_ff <= TMC_RST_INTCTL;
    end else begin
      if (wr_intctl) begin
        intctl_ff <= hwdata[7:0];
      end
      if (ovf_evt) begin
        intctl_ff[TMC_INT_OVF_FLAG] <= 1'b1;
      end
    end
  end

  // Request follows flag and enable; it cannot wake the core from Sleep.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      req_ff <= 1'b0;
    end else begin
      req_ff <= intctl_ff[TMC_INT_OVF_FLAG] && intctl_ff[TMC_INT_OVF_IE];
    end
  end

  assign overflow_irq_req = req_ff;

  // Sticky status: write-one-to-clear, a new event in the same cycle wins.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      status_ff <= '0;
    end else begin
      status_ff <= (status_ff & ~(wr_clear ? hwdata[TMC_EVT_W-1:0] : '0)) |
                   {ext_edge && option_ff[TMC_OPT_SRC_SEL], ovf_evt};
    end
  end

  // Enable register and the level interrupt, one cycle behind the status.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      enable_ff <= '0;
      irq_ff    <= 1'b0;
    end else begin
      if (wr_enable) begin
        enable_ff <= hwdata[TMC_EVT_W-1:0];
      end
      irq_ff <= |(status_ff & enable_ff);
    end
  end

  assign irq       = irq_ff;
  assign hreadyout = hready_ff;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  chk_write_pause: assert property (wr_count |=> !cnt_inc [*5])
    else $error("Count advanced during write pause.");
  chk_ovf_sets_flag: assert property (ovf_evt |=> intctl_ff[TMC_INT_OVF_FLAG]
                                      && count_ff == 8'h00)
    else $error("Wrap did not set overflow flag.");
  chk_req_gated: assert property (req_ff |-> $past(intctl_ff[TMC_INT_OVF_IE]))
    else $error("Request raised without enable.");
  chk_psc_write_clr: assert property (wr_count && psc_to_timer |=> psc_ff == 8'h00)
    else $error("Count write did not clear prescaler.");
  chk_psc_wdt_clr: assert property (watchdog_clear_instr && !psc_to_timer && !wr_option
                                    |=> psc_ff == 8'h00)
    else $error("Watchdog clear left prescaler.");
  chk_ext_phase: assert property (ext_edge |-> phase_ff inside {TMC_Q2, TMC_Q4})
    else $error("External edge outside Q2 or Q4.");
  chk_timer_phase: assert property (cnt_inc && !option_ff[TMC_OPT_SRC_SEL]
                                    |-> phase_ff == TMC_Q4)
    else $error("Timer step off instruction cycle.");
  chk_wdt_undivided: assert property (!psc_to_timer && src_evt && inhibit_ff == 2'h0
                                      && !wr_count && !sleep |-> cnt_inc)
    else $error("Timer divided while prescaler on watchdog.");
  chk_tap_wrap: assert property (cnt_inc && psc_to_timer
                                 |=> (psc_ff & $past(tap_mask)) == 8'h00)
    else $error("Timer step without tap wrap.");
  chk_sleep_freeze: assert property (sleep && !wr_count |=> $stable(count_ff))
    else $error("Count moved in Sleep.");
  chk_edge_polarity: assert property (ext_edge |-> ext_lvl
                                      == !option_ff[TMC_OPT_EDGE_SEL])
    else $error("Wrong external edge counted.");
  chk_flag_sticky: assert property (intctl_ff[TMC_INT_OVF_FLAG] && !wr_intctl
                                    |=> intctl_ff[TMC_INT_OVF_FLAG])
    else $error("Overflow flag dropped without a write.");

  cov_overflow: cover property (ovf_evt);
  cov_wdog_clear: cover property (watchdog_clear_instr && !psc_to_timer);
  cov_ext_count: cover property (cnt_inc && option_ff[TMC_OPT_SRC_SEL]);
  cov_irq: cover property (irq_ff && req_ff);

endmodule : tmc_timer
`default_nettype wire

// ===== verification/eight_bit_timer_counter_prescaler_bench.sv
// Self-checking bench for the 8-bit timer/counter with shared prescaler.
`timescale 1ns/1ps
`default_nettype none
module eight_bit_timer_counter_prescaler_bench
  import tmc_pkg::*;
;
  logic        clock;
  logic        arst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        pin;
  logic        sleep;
  logic        wd_tick;
  logic        wd_clr;
  logic        ovf_req;
  logic        irq;
  logic        pu_dis;
  logic        irq_edge;
  int          mismatches;
  int          n_checks;

  // -----------------------------------------------------------------
  // Design, pin source and clock
  // -----------------------------------------------------------------
  tmc_timer dut_u (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_count_input(pin),
    .sleep(sleep), .watchdog_tick(wd_tick), .watchdog_clear_instr(wd_clr),
    .overflow_irq_req(ovf_req), .irq(irq), .port_pullup_disable(pu_dis),
    .ext_irq_edge(irq_edge));
  tmc_pin_src src_u (.clock(clock), .pin(pin));

  // Free-running 100 MHz clock.
  always #5 clock = ~clock;

  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Waits for an edge with hready high; a bus that never answers ends the run.
  task automatic wait_ready();
    int i;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      summarize();
    end
  endtask : wait_ready

  // One single AHB-Lite transfer: address phase, then data phase.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= TMC_HTRANS_NONSEQ;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_ready();
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 8'h0, r);
  endtask : rd

  // Outputs are looked at a moment after the edge so that flop updates have landed.
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask : settle

  task automatic clr_wd();
    wd_clr <= 1'b1;
    @(posedge clock);
    wd_clr <= 1'b0;
  endtask : clr_wd

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] v;
    rd(TMC_ADDR_OPTION, v); check("option rst", v, 32'h0ff);
    rd(TMC_ADDR_COUNT, v);  check("count rst", v, 32'h0);
    rd(TMC_ADDR_INTCTL, v); check("intctl rst", v, 32'h0);
    rd(TMC_ADDR_ENABLE, v); check("enable rst", v, 32'h0);
    wr(8'h20, 8'hff);
    rd(8'h20, v);           check("unmapped", v, 32'h0);
    check("pullup rst", {31'h0, pu_dis}, 32'h1);
    check("irq edge rst", {31'h0, irq_edge}, 32'h1);
    check("hresp okay", {31'h0, hresp}, 32'h0);
    wr(TMC_ADDR_OPTION, 8'h3f);
    settle();
    check("pullup off", {31'h0, pu_dis}, 32'h0);
    check("irq edge off", {31'h0, irq_edge}, 32'h0);
    wr(TMC_ADDR_OPTION, 8'hbf);
    settle();
    check("pullup on", {31'h0, pu_dis}, 32'h1);
    $display("test reset done");
  endtask : t_reset

  // Moving the prescaler to the watchdog, then timing the pause and the 1:1 rate.
  task automatic t_pause();
    logic [31:0] a;
    logic [31:0] b;
    int          n;
    clr_wd();
    wr(TMC_ADDR_COUNT, 8'h00);
    wr(TMC_ADDR_OPTION, 8'h08);
    clr_wd();
    wr(TMC_ADDR_OPTION, 8'h0d);
    wr(TMC_ADDR_COUNT, 8'h10);
    n = 0;
    do begin
      rd(TMC_ADDR_COUNT, a);
      n++;
    end while (a === 32'h10 && n < 20);
    // Two skipped Q4 ticks put the first step 9 to 12 clocks after the write.
    check("pause", {31'h0, (2 * n >= 12 && 2 * n <= 14)}, 32'h1);
    rd(TMC_ADDR_COUNT, a);
    repeat (38) @(posedge clock);
    rd(TMC_ADDR_COUNT, b);
    check("rate 1:1", b - a, 32'd10);
    $display("test pause done");
  endtask : t_pause

  // Every rate code with the prescaler on the timer; the write pause costs one of six periods.
  task automatic t_rates();
    logic [31:0] v;
    int          per;
    clr_wd();
    for (int r = 0; r < 8; r++) begin
      per = 4 << (r + 1);
      wr(TMC_ADDR_OPTION, 8'(r));
      wr(TMC_ADDR_COUNT, 8'h00);
      repeat (per * 6) @(posedge clock);
      rd(TMC_ADDR_COUNT, v);
      check("rate code", v, 32'd5);
    end
    $display("test rates done");
  endtask : t_rates

  task automatic t_irq();
    logic [31:0] v;
    wr(TMC_ADDR_OPTION, 8'h08);
    wr(TMC_ADDR_INTCTL, 8'h00);
    wr(TMC_ADDR_CLEAR, 8'h03);
    wr(TMC_ADDR_COUNT, 8'hfc);
    repeat (40) @(posedge clock);
    rd(TMC_ADDR_INTCTL, v); check("flag set", v & 32'h4, 32'h4);
    rd(TMC_ADDR_STATUS, v); check("status set", v & 32'h1, 32'h1);
    check("req masked", {31'h0, ovf_req}, 32'h0);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(TMC_ADDR_INTCTL, 8'h24);
    settle();
    check("req on", {31'h0, ovf_req}, 32'h1);
    wr(TMC_ADDR_ENABLE, 8'h01);
    settle();
    check("irq on", {31'h0, irq}, 32'h1);
    wr(TMC_ADDR_ENABLE, 8'h00);
    settle();
    check("irq off", {31'h0, irq}, 32'h0);
    rd(TMC_ADDR_STATUS, v); check("status sticky", v & 32'h1, 32'h1);
    wr(TMC_ADDR_CLEAR, 8'h01);
    rd(TMC_ADDR_STATUS, v); check("status clr", v & 32'h1, 32'h0);
    rd(TMC_ADDR_INTCTL, v); check("flag sticky", v & 32'h4, 32'h4);
    wr(TMC_ADDR_INTCTL, 8'h20);
    settle();
    check("req clr", {31'h0, ovf_req}, 32'h0);
    $display("test irq done");
  endtask : t_irq

  task automatic t_counter();
    logic [31:0] v;
    wr(TMC_ADDR_OPTION, 8'h28);
    wr(TMC_ADDR_COUNT, 8'h00);
    repeat (10) @(posedge clock);
    src_u.toggle(3);
    rd(TMC_ADDR_COUNT, v); check("rising edges", v, 32'd2);
    wr(TMC_ADDR_OPTION, 8'h38);
    wr(TMC_ADDR_COUNT, 8'h00);
    repeat (10) @(posedge clock);
    src_u.toggle(1);
    rd(TMC_ADDR_COUNT, v); check("falling edge", v, 32'd1);
    rd(TMC_ADDR_STATUS, v); check("edge status", v & 32'h2, 32'h2);
    $display("test counter done");
  endtask : t_counter

  // Watchdog ticks fill the prescaler; the clear must empty it before it moves back.
  task automatic t_wdog();
    logic [31:0] a;
    logic [31:0] v;
    wr(TMC_ADDR_OPTION, 8'h28);
    rd(TMC_ADDR_COUNT, a);
    repeat (3) begin
      wd_tick <= 1'b1;
      @(posedge clock);
      wd_tick <= 1'b0;
      @(posedge clock);
    end
    rd(TMC_ADDR_COUNT, v); check("wdog ticks", v, a);
    clr_wd();
    wr(TMC_ADDR_OPTION, 8'h20);
    src_u.toggle(2);
    rd(TMC_ADDR_COUNT, v); check("half step", v, a);
    src_u.toggle(2);
    rd(TMC_ADDR_COUNT, v); check("full step", v, a + 32'd1);
    $display("test wdog done");
  endtask : t_wdog

  task automatic t_sleep();
    logic [31:0] a;
    logic [31:0] b;
    wr(TMC_ADDR_OPTION, 8'h08);
    wr(TMC_ADDR_COUNT, 8'h40);
    repeat (12) @(posedge clock);
    sleep <= 1'b1;
    repeat (2) @(posedge clock);
    rd(TMC_ADDR_COUNT, a);
    repeat (40) @(posedge clock);
    rd(TMC_ADDR_COUNT, b); check("frozen", b, a);
    sleep <= 1'b0;
    repeat (40) @(posedge clock);
    rd(TMC_ADDR_COUNT, b); check("wakes", {31'h0, b !== a}, 32'h1);
    $display("test sleep done");
  endtask : t_sleep

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    sleep = 1'b0;
    wd_tick = 1'b0;
    wd_clr = 1'b0;
    mismatches = 0;
    n_checks = 0;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_pause();
    t_rates();
    t_irq();
    t_counter();
    t_wdog();
    t_sleep();
    summarize();
  end
endmodule : eight_bit_timer_counter_prescaler_bench
`default_nettype wire

// ===== verification/tmc_pin_src.sv
// Behavioural source of the external count pin for the timer/counter.
`timescale 1ns/1ps
`default_nettype none
module tmc_pin_src (
  input  wire logic clock,
  output logic      pin
);
  // The pin idles low; it is a plain driven line with no pull.
  initial pin = 1'b0;

  // Each level is held seven clocks, longer than the two that the phase samples need.
  task automatic toggle(input int n);
    repeat (n) begin
      @(posedge clock);
      pin <= ~pin;
      repeat (6) @(posedge clock);
    end
  endtask : toggle
endmodule : tmc_pin_src
`default_nettype wire
